// File: ring_node_pkg.sv
package ring_node_pkg;
   // ******************************************************************
   // geometry
   // ******************************************************************
   localparam int SYM_W = 42;
   localparam int LANES = 6;
   localparam int BEATS = 7;
   localparam logic [2:0] LAST_BEAT = 3'h6;
   localparam int TYPE_LSB = 40;
   localparam int CHECK_LSB = 32;
   localparam int ID_W = 4;
   localparam logic [ID_W-1:0] MASTER_ID = 4'h0;
   // ******************************************************************
   // client type codes
   // ******************************************************************
   localparam logic [1:0] TYPE_NULL = 2'h0;
   localparam logic [1:0] TYPE_HEAD = 2'h1;
   localparam logic [1:0] TYPE_DATA = 2'h2;
   localparam logic [1:0] TYPE_FRAME = 2'h3;
   // ******************************************************************
   // timing
   // ******************************************************************
   localparam int CLOCK_MHZ = 100;
   localparam int LOSS_NS = 1000;
   localparam int LOSS_CYCLES = LOSS_NS * CLOCK_MHZ / 1000;
   localparam int INIT_SYMBOLS = 4;
   // ******************************************************************
   // register map
   // ******************************************************************
   localparam logic [7:0] STATUS_ADDR = 8'h00;
   localparam logic [7:0] MASK_ADDR = 8'h04;
   localparam logic [7:0] NODE_ADDR = 8'h08;
   localparam logic [7:0] RXSYM_ADDR = 8'h0c;
   localparam int EV_W = 3;
   localparam int EV_RX = 0;
   localparam int EV_INIT = 1;
   localparam int EV_FAIL = 2;
   localparam logic [EV_W-1:0] MASK_RESET = 3'h0;
   // ******************************************************************
   // node state
   // ******************************************************************
   typedef enum logic [1:0] {
      idle_s = 2'h0,
      init_s = 2'h1,
      run_s = 2'h3,
      fail_s = 2'h2
   } node_state_t;
endpackage : ring_node_pkg

// File: ring_node_control_clocking.sv
`timescale 1ns/10ps
// What this block does
// RULE1: leaving reset starts the initialization sequence.
// RULE2: a detected failure raises the failure output, held until reset.
// RULE3: with pipelining off, type and symbol at both client ports align.
// RULE4: with pipelining on, receive type leads receive symbol by a clock.
// RULE5: with pipelining on, the client's transmit type trails its symbol.
// RULE6: ring master select gives node id 0 and leads ring initialization.
// RULE7: clock source select picks local ring clock or upstream clock.
// RULE8: the system runs the local ring clock only when it is selected.
// RULE9: the locked clock output follows the selected ring clock.
// RULE10: each 42-bit symbol arrives over six upstream lanes, reassembled.
// RULE11: downstream clock comes from the ring clock, lanes change with it.
// RULE12: each 42-bit symbol leaves over six downstream lanes.
module ring_node_control_clocking (
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // strap and control pins
   input wire logic ring_master_select,
   input wire logic clock_source_select,
   input wire logic pipeline_select,
   output logic failure_out,
   // ring clocks
   input wire logic local_ring_clock_in,
   input wire logic upstream_link_clock,
   output logic locked_clock_output,
   // ring lanes
   input wire logic [5:0] upstream_sub_symbol_lanes,
   output logic downstream_link_clock,
   output logic [5:0] downstream_sub_symbol_lanes,
   // client transmit port
   input wire logic [1:0] tx_type,
   input wire logic [31:0] tx_symbol,
   output logic tx_ok,
   // client receive port
   output logic [1:0] rx_type,
   output logic [31:0] rx_symbol,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [31:0] reg_rdata,
   output logic irq
);
   // ******************************************************************
   // state
   // ******************************************************************
   typedef struct packed {
      logic [2:0] lrc_sync;
      logic [2:0] up_sync;
      logic [5:0] lane_s1;
      logic [5:0] lane_s2;
      logic [1:0] pipe_sync;
      logic [1:0] master_sync;
      logic [1:0] csrc_sync;
      ring_node_pkg::node_state_t state;
      logic master;
      logic [3:0] node_id;
      logic [2:0] init_cnt;
      logic [7:0] loss_cnt;
      logic [2:0] up_beat;
      logic [41:0] up_sym;
      logic [31:0] last_sym;
      logic [2:0] dn_beat;
      logic [41:0] dn_sym;
      logic [5:0] dn_lanes;
      logic dn_clk;
      logic lock_clk;
      logic pend_valid;
      logic [41:0] pend;
      logic [31:0] tx_sym_d;
      logic tx_ok;
      logic [1:0] rx_type;
      logic [31:0] rx_sym;
      logic rx_late;
      logic [31:0] rx_late_sym;
      logic failure;
      logic [2:0] status;
      logic [2:0] mask;
      logic [31:0] rdata;
      logic irq;
   } node_regs_t;

   node_regs_t r;
   node_regs_t n;

   localparam logic [7:0] LOSS_LIMIT = 8'(ring_node_pkg::LOSS_CYCLES);
   localparam logic [2:0] INIT_LAST = 3'(ring_node_pkg::INIT_SYMBOLS - 1);

   // ******************************************************************
   // symbol helpers
   // ******************************************************************
   function automatic logic [7:0] check_of(input logic [1:0] t,
                                           input logic [31:0] d);
      check_of = d[7:0] ^ d[15:8] ^ d[23:16] ^ d[31:24] ^ {6'h00, t};
   endfunction : check_of

   function automatic logic [41:0] make_sym(input logic [1:0] t,
                                            input logic [31:0] d);
      make_sym = {t, check_of(t, d), d};
   endfunction : make_sym

   // ******************************************************************
   // next state
   // ******************************************************************
   logic ring_level;
   logic ring_prev;
   logic ring_rise;
   logic up_done;
   logic [41:0] got;
   logic got_ok;
   logic [1:0] got_type;
   logic [1:0] eff_type;
   logic [31:0] eff_sym;
   logic take_tx;
   logic [2:0] ev;

   always_comb begin
      n = r;
      ev = 3'h0;
      take_tx = 1'b0;
      // pins from outside pass two flops before use
      n.lrc_sync = {r.lrc_sync[1:0], local_ring_clock_in};
      n.up_sync = {r.up_sync[1:0], upstream_link_clock};
      n.lane_s1 = upstream_sub_symbol_lanes;
      n.lane_s2 = r.lane_s1;
      n.pipe_sync = {r.pipe_sync[0], pipeline_select};
      n.master_sync = {r.master_sync[0], ring_master_select};
      n.csrc_sync = {r.csrc_sync[0], clock_source_select};

      // local clock is only a source while selected; idle low otherwise
      if (r.csrc_sync[1]) begin // RULE7 RULE8
         ring_level = r.lrc_sync[1];
         ring_prev = r.lrc_sync[2];
      end else begin
         ring_level = r.up_sync[1];
         ring_prev = r.up_sync[2];
      end
      ring_rise = ring_level & ~ring_prev;

      // outputs track the selected clock, so they are frequency locked
      n.lock_clk = ring_level; // RULE9
      n.dn_clk = ring_level; // RULE11

      // loss of ring clock counts as a failure
      // a stalled ring clock ends in fail_s; only reset recovers from it
      if (ring_rise || r.state == ring_node_pkg::idle_s) begin
         n.loss_cnt = 8'h00;
      end else if (r.loss_cnt != LOSS_LIMIT) begin
         n.loss_cnt = r.loss_cnt + 8'h01;
      end

      // ****************************************************************
      // upstream reassembly, lane bits enter at the high end and shift down
      // ****************************************************************
      up_done = 1'b0;
      got = r.up_sym;
      if (ring_rise) begin // RULE10
         got = {r.lane_s2, r.up_sym[41:6]};
         n.up_sym = got;
         if (r.up_beat == ring_node_pkg::LAST_BEAT) begin
            n.up_beat = 3'h0;
            up_done = 1'b1;
         end else begin
            n.up_beat = r.up_beat + 3'h1;
         end
      end
      got_type = got[41:40];
      got_ok = got[39:32] == check_of(got_type, got[31:0]);
      // keep the last whole symbol for software; the shifter is mid-word
      if (up_done) begin
         n.last_sym = got[31:0];
      end

      // ****************************************************************
      // client transmit pairing
      // ****************************************************************
      // the held copy is the symbol that a late type describes
      n.tx_sym_d = tx_symbol;
      if (r.pipe_sync[1]) begin // RULE5
         eff_type = tx_type;
         eff_sym = r.tx_sym_d;
      end else begin // RULE3
         eff_type = tx_type;
         eff_sym = tx_symbol;
      end
      if (r.state == ring_node_pkg::run_s && r.tx_ok &&
          eff_type != ring_node_pkg::TYPE_NULL) begin
         take_tx = 1'b1;
         n.pend = make_sym(eff_type, eff_sym);
         n.pend_valid = 1'b1;
      end

      // ****************************************************************
      // client receive delivery
      // ****************************************************************
      n.rx_type = ring_node_pkg::TYPE_NULL;
      n.rx_late = 1'b0;
      if (r.rx_late) begin
         n.rx_sym = r.rx_late_sym;
      end
      if (up_done && got_ok && r.state == ring_node_pkg::run_s &&
          got_type != ring_node_pkg::TYPE_NULL) begin
         ev[ring_node_pkg::EV_RX] = 1'b1;
         n.rx_type = got_type;
         if (r.pipe_sync[1]) begin // RULE4
            n.rx_late = 1'b1;
            n.rx_late_sym = got[31:0];
         end else begin // RULE3
            n.rx_sym = got[31:0];
         end
      end

      // ****************************************************************
      // node state
      // ****************************************************************
      unique case (r.state)
         ring_node_pkg::idle_s: begin
            n.state = ring_node_pkg::init_s; // RULE1
            n.init_cnt = 3'h0;
         end
         ring_node_pkg::init_s: begin
            // the strap chain is cleared by reset, so the role is read all
            // through init; the strap must not move until the node runs
            n.master = r.master_sync[1];
            if (r.master_sync[1]) begin // RULE6
               n.node_id = ring_node_pkg::MASTER_ID;
               // master leads: it sends its id frames, then runs
               if (!r.pend_valid && !take_tx) begin
                  n.pend = make_sym(ring_node_pkg::TYPE_FRAME,
                                    {28'h0000000, ring_node_pkg::MASTER_ID});
                  n.pend_valid = 1'b1;
                  if (r.init_cnt == INIT_LAST) begin
                     n.state = ring_node_pkg::run_s;
                     ev[ring_node_pkg::EV_INIT] = 1'b1;
                  end else begin
                     n.init_cnt = r.init_cnt + 3'h1;
                  end
               end
            end else if (up_done && got_ok &&
                         got_type == ring_node_pkg::TYPE_FRAME) begin
               // take the next id after the sender and pass it on
               n.node_id = got[3:0] + 4'h1;
               n.pend = make_sym(ring_node_pkg::TYPE_FRAME,
                                 {28'h0000000, got[3:0] + 4'h1});
               n.pend_valid = 1'b1;
               n.state = ring_node_pkg::run_s;
               ev[ring_node_pkg::EV_INIT] = 1'b1;
            end
         end
         ring_node_pkg::run_s: begin
         end
         ring_node_pkg::fail_s: begin
         end
      endcase

      // failure is sticky; only reset leaves fail_s
      if (r.state != ring_node_pkg::idle_s &&
          r.state != ring_node_pkg::fail_s &&
          ((up_done && !got_ok) || r.loss_cnt == LOSS_LIMIT)) begin // RULE2
         n.state = ring_node_pkg::fail_s;
         n.failure = 1'b1;
         ev[ring_node_pkg::EV_FAIL] = 1'b1;
      end

      // ****************************************************************
      // downstream split, lanes move on the same edge as the clock out
      // ****************************************************************
      if (ring_rise) begin // RULE11 RULE12
         n.dn_lanes = r.dn_sym[5:0];
         if (r.dn_beat == ring_node_pkg::LAST_BEAT) begin
            n.dn_beat = 3'h0;
            if (r.pend_valid) begin
               n.dn_sym = r.pend;
               n.pend_valid = take_tx;
            end else begin
               n.dn_sym = make_sym(ring_node_pkg::TYPE_NULL, 32'h00000000);
            end
         end else begin
            n.dn_beat = r.dn_beat + 3'h1;
            n.dn_sym = {6'h00, r.dn_sym[41:6]};
         end
      end
      n.tx_ok = !n.pend_valid && n.state == ring_node_pkg::run_s;

      // ****************************************************************
      // registers: read of status clears it, a new event wins
      // ****************************************************************
      n.rdata = 32'h00000000;
      if (reg_read) begin
         unique case (reg_addr)
            ring_node_pkg::STATUS_ADDR: begin
               n.rdata = {29'h00000000, r.status};
               n.status = 3'h0;
            end
            ring_node_pkg::MASK_ADDR: begin
               n.rdata = {29'h00000000, r.mask};
            end
            ring_node_pkg::NODE_ADDR: begin
               n.rdata = {24'h000000, r.state, r.master, r.failure,
                          r.node_id};
            end
            ring_node_pkg::RXSYM_ADDR: begin
               n.rdata = r.last_sym;
            end
            default: begin
               n.rdata = 32'h00000000;
            end
         endcase
      end
      if (reg_write && reg_addr == ring_node_pkg::MASK_ADDR) begin
         n.mask = reg_wdata[2:0];
      end
      n.status = n.status | ev;
      n.irq = |(n.status & n.mask);
   end

   // ******************************************************************
   // registers
   // ******************************************************************
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         r <= '0;
         r.state <= ring_node_pkg::idle_s; // RULE2
         r.mask <= ring_node_pkg::MASK_RESET;
         r.dn_sym <= 42'h000_0000_0000;
      end else begin
         r <= n;
      end
   end

   // ******************************************************************
   // outputs
   // ******************************************************************
   assign failure_out = r.failure;
   assign locked_clock_output = r.lock_clk;
   assign downstream_link_clock = r.dn_clk;
   assign downstream_sub_symbol_lanes = r.dn_lanes;
   assign tx_ok = r.tx_ok;
   assign rx_type = r.rx_type;
   assign rx_symbol = r.rx_sym;
   assign reg_rdata = r.rdata;
   assign irq = r.irq;
endmodule : ring_node_control_clocking

// File: ring_node_checker.sv
`timescale 1ns/10ps
module ring_node_checker (
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // pins and ring side
   input wire logic clock_source_select,
   input wire logic pipeline_select,
   input wire logic failure_out,
   input wire logic local_ring_clock_in,
   input wire logic upstream_link_clock,
   input wire logic locked_clock_output,
   input wire logic downstream_link_clock,
   input wire logic [5:0] downstream_sub_symbol_lanes,
   // client and registers
   input wire logic [1:0] tx_type,
   input wire logic tx_ok,
   input wire logic [1:0] rx_type,
   input wire logic [31:0] rx_symbol,
   input wire logic reg_read,
   input wire logic [31:0] reg_rdata
);
   // ****
   // properties on the system clock
   // ****
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   AST_FAIL_HOLD: assert property (failure_out |=> failure_out)
      else $error("failure output dropped");
   AST_FAIL_CLR: assert property ($fell(reset) |-> !failure_out)
      else $error("failure output survived reset");
   // the select passes a sync chain, so let it settle first
   AST_LOCK: assert property ((!$changed(clock_source_select))[*7] |->
      locked_clock_output == (clock_source_select ?
      $past(local_ring_clock_in, 3) : $past(upstream_link_clock, 3)))
      else $error("locked clock not following selected clock");
   AST_DN_CLK: assert property (downstream_link_clock == locked_clock_output)
      else $error("downstream clock not derived from ring clock");
   AST_DN_LANES: assert property (!$rose(downstream_link_clock) |->
      $stable(downstream_sub_symbol_lanes))
      else $error("downstream lanes moved off the clock edge");
   AST_RX_PULSE: assert property (rx_type != 2'h0 |=> rx_type == 2'h0)
      else $error("receive type longer than one cycle");
   AST_RX_FLAT: assert property (!pipeline_select && $changed(rx_symbol) |->
      rx_type != 2'h0)
      else $error("receive symbol without type in same cycle");
   AST_RX_LEAD: assert property (pipeline_select && $changed(rx_symbol) |->
      $past(rx_type) != 2'h0)
      else $error("receive type did not lead symbol");
   AST_RD_IDLE: assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
      else $error("read data outside read cycle");
   AST_TX_TAKE: assert property (tx_ok && tx_type != 2'h0 |=> !tx_ok)
      else $error("transmit ok stayed after accept");
endmodule : ring_node_checker

// File: ring_upstream_model.sv
`timescale 1ns/10ps
module ring_upstream_model (
   // control
   input wire logic reset,
   input wire logic run,
   input wire logic [41:0] next_symbol,
   // ring side
   output logic ring_clock,
   output logic [5:0] lanes
);
   logic [41:0] shift_r;
   int beat;
   // ****
   // ring clock, offset so it never meets a system clock edge
   // ****
   initial begin
      ring_clock = 1'b0;
      #1;
      forever begin
         #62.5;
         ring_clock = (run && !reset) ? !ring_clock : 1'b0;
      end
   end
   // a beat is launched on the falling edge, whole symbols only
   always @(negedge ring_clock or posedge reset or negedge reset) begin
      if (reset) begin
         beat = 6;
      end else if (beat == 6) begin
         beat = 0;
         shift_r = next_symbol;
      end else begin
         beat++;
      end
   end
   assign lanes = shift_r[6*beat +: 6];
endmodule : ring_upstream_model

// File: ring_node_control_clocking_tb_top.sv
`timescale 1ns/10ps
module ring_node_control_clocking_tb_top;
   // ****
   // signals
   // ****
   logic clock, reset, master, cks, pipe, run, model_clk, dn_prev;
   logic failure_out, locked_clock_output, downstream_link_clock, tx_ok, irq;
   logic reg_write, reg_read;
   logic [1:0] tx_type, rx_type;
   logic [5:0] up_lanes, dn_lanes;
   logic [7:0] reg_addr;
   logic [31:0] tx_symbol, rx_symbol, reg_wdata, reg_rdata, rd;
   logic [41:0] up_sym, dn_sh;
   logic [41:0] dn_q[$];
   int dn_beat, num_errors = 0, cmp_count = 0;
   ring_node_control_clocking ring_node_control_clocking_inst (
      .clock, .reset, .ring_master_select(master),
      .clock_source_select(cks), .pipeline_select(pipe), .failure_out,
      .local_ring_clock_in(cks ? model_clk : 1'b0),
      .upstream_link_clock(cks ? 1'b0 : model_clk), .locked_clock_output,
      .upstream_sub_symbol_lanes(up_lanes), .downstream_link_clock,
      .downstream_sub_symbol_lanes(dn_lanes), .tx_type, .tx_symbol, .tx_ok,
      .rx_type, .rx_symbol, .reg_addr, .reg_wdata, .reg_write, .reg_read,
      .reg_rdata, .irq);
   ring_upstream_model ring_upstream_model_inst (.reset, .run,
      .next_symbol(up_sym), .ring_clock(model_clk), .lanes(up_lanes));
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   initial begin
      #200000;
      num_errors++;
      $display("[FAIL] %0t watchdog expired", $time);
      give_verdict();
   end
   // rebuild downstream symbols, beat 0 first
   initial forever begin
      @(posedge clock);
      #1;
      if (reset) begin
         dn_beat = 0;
      end else if (downstream_link_clock && !dn_prev) begin
         dn_sh = {dn_lanes, dn_sh[41:6]};
         dn_beat++;
         if (dn_beat == 7) begin
            dn_q.push_back(dn_sh);
            dn_beat = 0;
         end
      end
      dn_prev = downstream_link_clock;
   end
   // ****
   // helpers
   // ****
   function automatic logic [41:0] mk(input logic [1:0] t,
      input logic [31:0] d);
      return {t, d[7:0] ^ d[15:8] ^ d[23:16] ^ d[31:24] ^ {6'h0, t}, d};
   endfunction : mk
   function automatic int seen(input logic [41:0] s);
      seen = 0;
      foreach (dn_q[i]) begin
         seen += int'(dn_q[i] === s);
      end
   endfunction : seen
   task automatic chk(input logic [41:0] got, exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clock);
      reg_write <= 1'b0;
   endtask : wr
   task automatic rdr(input logic [7:0] a);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clock);
      reg_read <= 1'b0;
      #1 rd = reg_rdata;
      @(posedge clock);
   endtask : rdr
   task automatic restart(input logic m, c, p, input logic [41:0] s);
      reset <= 1'b1;
      master <= m;
      cks <= c;
      pipe <= p;
      up_sym <= s;
      repeat (12) @(posedge clock);
      dn_q.delete();
      reset <= 1'b0;
      @(posedge clock);
   endtask : restart
   task automatic wait_cond(input int which);
      bit hit;
      hit = 1'b0;
      for (int n = 0; n < 400; n++) begin
         @(posedge clock);
         #1;
         hit = (which == 0 && rx_type === ring_node_pkg::TYPE_DATA) ||
               (which == 1 && tx_ok === 1'b1);
         if (hit) break;
      end
      if (!hit) begin
         num_errors++;
         $display("[FAIL] %0t wait for design timed out", $time);
      end
   endtask : wait_cond
   task automatic wait_run();
      rdr(ring_node_pkg::NODE_ADDR);
      for (int n = 0; n < 500 && rd[7:6] !== 2'h3; n++) begin
         rdr(ring_node_pkg::NODE_ADDR);
      end
   endtask : wait_run
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : give_verdict
   // ****
   // tests
   // ****
   initial begin
      run <= 1'b1;
      tx_type <= 2'h0;
      tx_symbol <= 32'h0;
      reg_addr <= 8'h0;
      reg_wdata <= 32'h0;
      reg_write <= 1'b0;
      reg_read <= 1'b0;
      restart(1'b1, 1'b1, 1'b0, 42'h0);
      rdr(ring_node_pkg::NODE_ADDR);
      chk(42'(rd[7:6]), 42'h1, "state after reset");
      wait_run();
      chk(42'(rd[7:0]), 42'he0, "master node word");
      repeat (200) @(posedge clock);
      chk(42'(seen(mk(2'h3, 32'h0))), 42'h4, "master frames");
      rdr(ring_node_pkg::STATUS_ADDR);
      chk(42'({rd[1], irq}), 42'h2, "init event, masked irq");
      $display("test master done");
      for (int p = 0; p < 2; p++) begin
         restart(1'b0, 1'b0, p[0], mk(ring_node_pkg::TYPE_FRAME, 32'h5));
         wait_run();
         chk(42'(rd[7:0]), 42'hc6, "follower node word");
         up_sym <= mk(ring_node_pkg::TYPE_DATA, 32'h1234abcd);
         wait_cond(0);
         chk(42'(rx_type), 42'h2, "rx type");
         if (p == 1) begin
            @(posedge clock);
            #1;
         end
         chk(42'(rx_symbol), 42'h1234abcd, "rx symbol");
         @(posedge clock);
         rdr(ring_node_pkg::RXSYM_ADDR);
         chk(42'(rd), 42'h1234abcd, "rx symbol register");
         wait_cond(1);
         @(posedge clock);
         tx_symbol <= 32'h0badf00d;
         tx_type <= p ? 2'h0 : ring_node_pkg::TYPE_DATA;
         @(posedge clock);
         tx_type <= p ? ring_node_pkg::TYPE_DATA : 2'h0;
         @(posedge clock);
         tx_type <= 2'h0;
         repeat (300) @(posedge clock);
         chk(42'(seen(mk(2'h2, 32'h0badf00d))), 42'h1, "tx out");
         chk(42'(seen(mk(2'h3, 32'h6))), 42'h1, "follower frame");
         $display("test follower done");
      end
      wr(ring_node_pkg::MASK_ADDR, 32'h4);
      rdr(ring_node_pkg::MASK_ADDR);
      chk(42'(rd), 42'h4, "mask readback");
      run <= 1'b0;
      repeat (150) @(posedge clock);
      #1;
      chk(42'({failure_out, irq}), 42'h3, "failure and irq");
      run <= 1'b1;
      repeat (100) @(posedge clock);
      rdr(ring_node_pkg::STATUS_ADDR);
      chk(42'({failure_out, rd[2]}), 42'h3, "failure held");
      rdr(ring_node_pkg::STATUS_ADDR);
      chk(42'({rd[2:0], irq}), 42'h0, "status cleared by read");
      rdr(8'h10);
      chk(42'(rd), 42'h0, "unmapped read");
      restart(1'b1, 1'b1, 1'b0, 42'h0);
      #1;
      chk(42'(failure_out), 42'h0, "failure after reset");
      $display("test failure done");
      give_verdict();
   end
endmodule : ring_node_control_clocking_tb_top
bind ring_node_control_clocking ring_node_checker ring_node_checker_inst (
   .clock, .reset, .clock_source_select, .pipeline_select, .failure_out,
   .local_ring_clock_in, .upstream_link_clock, .locked_clock_output,
   .downstream_link_clock, .downstream_sub_symbol_lanes, .tx_type, .tx_ok,
   .rx_type, .rx_symbol, .reg_read, .reg_rdata);
